// ---- oc6_divider.sv ----
// output divider: 50 percent duty, ratio value plus one, counts both source edges
// assumes i_edge is a one-cycle mark for every source transition
`timescale 1ns/1ps
`include "oc6_params.svh"

module oc6_divider (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_enable,
  input wire logic i_edge,
  input wire logic [7:0] i_ratio,
  output logic o_clk
);

  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic clk_reg;
  logic clk_next;
  logic wrap;

  // toggle after ratio plus one edges gives a period of ratio plus one source periods
  assign wrap = i_edge && (cnt_reg >= i_ratio); // R07
  assign cnt_next = !i_enable ? 8'h00 : wrap ? 8'h00 : i_edge ? cnt_reg + 8'h01 : cnt_reg; // R08
  assign clk_next = !i_enable ? 1'b0 : wrap ? !clk_reg : clk_reg; // R08

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      cnt_reg <= 8'h00;
      clk_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      clk_reg <= clk_next;
    end
  end

  assign o_clk = clk_reg;

  chk_div_toggle: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R07
    (i_enable && i_edge && cnt_reg >= i_ratio) |=> (o_clk != $past(o_clk)))
    else $error("divider did not toggle at ratio");

  chk_div_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R07
    (i_enable && !(i_edge && cnt_reg >= i_ratio)) |=> $stable(o_clk))
    else $error("divider toggled early");

  chk_div_gated: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R08
    !i_enable |=> (!o_clk && cnt_reg == 8'h00))
    else $error("divider ran while not selected");

endmodule : oc6_divider

// ---- oc6_nvm_if.sv ----
// carrier between the control block and its non-volatile image store
// assumes one clock shared by both ends
`timescale 1ns/1ps

interface oc6_nvm_if;
  logic rd_en;
  logic rd_addr;
  logic [7:0] rd_data;
  logic wr_en;
  logic wr_addr;
  logic [7:0] wr_data;

  modport ctrl (output rd_en, output rd_addr, input rd_data, output wr_en, output wr_addr, output wr_data);
  modport mem (input rd_en, input rd_addr, output rd_data, input wr_en, input wr_addr, input wr_data);
endinterface : oc6_nvm_if

// ---- oc6_nvm_mem.sv ----
// two-word non-volatile image of the channel six registers
// assumes content survives reset; factory image equals the register reset values
`timescale 1ns/1ps
`include "oc6_params.svh"

module oc6_nvm_mem (
  input wire logic i_mclk,
  oc6_nvm_if.mem nvm
);

  // factory image, given at declaration so the clocked process stays the only writer
  logic [7:0] mem_reg [0:1] = '{`OC6_CTRL_RST, `OC6_DIV_RST};
  logic [7:0] rd_data_reg = `OC6_RD_IDLE;

  always_ff @(posedge i_mclk) begin
    if (nvm.wr_en) begin
      mem_reg[nvm.wr_addr] <= nvm.wr_data;
    end
    if (nvm.rd_en) begin
      rd_data_reg <= mem_reg[nvm.rd_addr];
    end
  end

  assign nvm.rd_data = rd_data_reg;

endmodule : oc6_nvm_mem

// ---- oc6_output_ctrl.sv ----
// channel six output control: source mux, divider, driver format, register port
// assumes sampled clock inputs synchronous to i_mclk; first access after o_init_done
//
// Behaviour
// R01 - source field: synth, reserved, primary, secondary
// R02 - format: off, AC differential, HCSL, LVCMOS
// R03 - LVCMOS first mode drives positive pin
// R04 - differential first mode sets tail current
// R05 - second mode: HCSL load or negative pin
// R06 - divider is full eight bits of own register
// R07 - divide ratio is value plus one
// R08 - divider only acts on synthesizer paths
// R09 - divider resets to five, divide by six
// R10 - reference sources bypass the divider
// R11 - doubler on gives doubled reference
// R12 - start-up loads image, writes override
// R13 - reserved source code yields no clock
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`include "oc6_params.svh"

module oc6_output_ctrl (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rd_data,
  input wire logic i_nvm_wr,
  input wire logic i_nvm_addr,
  input wire logic [7:0] i_nvm_data,
  input wire logic i_synth_clk,
  input wire logic i_second_synth_clk,
  input wire logic i_second_synth_path_sel,
  input wire logic i_pri_ref,
  input wire logic i_pri_ref_x2,
  input wire logic i_sec_ref,
  input wire logic i_sec_ref_x2,
  input wire logic i_ref_doubler_en,
  output logic o_out_p,
  output logic o_out_p_oe,
  output logic o_out_n,
  output logic o_out_n_oe,
  output logic [4:0] o_tail_ma,
  output logic [7:0] o_load_ohm,
  output logic o_div_active,
  output logic o_init_done
);

  // --------------------------------------------------------------------
  // functions
  // --------------------------------------------------------------------
  // returns {enable, level} for one LVCMOS pin
  function automatic logic [1:0] oc6_pin_drive(input logic [1:0] mode, input logic clk);
    logic [1:0] r;
    r = 2'b00;
    case (oc6_pkg::oc6_pin_t'(mode))
      oc6_pkg::OC6_PIN_TRI: r = 2'b00;
      oc6_pkg::OC6_PIN_LOW: r = 2'b10;
      oc6_pkg::OC6_PIN_INV: r = {1'b1, !clk};
      oc6_pkg::OC6_PIN_TRUE: r = {1'b1, clk};
      default: r = 2'b00;
    endcase
    return r;
  endfunction : oc6_pin_drive

  // --------------------------------------------------------------------
  // registers and start-up load
  // --------------------------------------------------------------------
  oc6_nvm_if nvm ();

  oc6_nvm_mem u_nvm (
    .i_mclk(i_mclk),
    .nvm(nvm.mem)
  );

  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic [7:0] div_reg;
  logic [7:0] div_next;
  logic [7:0] rd_data_reg;
  logic [7:0] rd_data_next;
  logic init_done_reg;
  oc6_pkg::oc6_state_t state_reg;
  oc6_pkg::oc6_state_t state_next;

  wire hit_ctrl = (i_addr == `OC6_ADDR_CTRL);
  wire hit_div = (i_addr == `OC6_ADDR_DIV);
  wire wr_ctrl = i_wr && hit_ctrl;
  wire wr_div = i_wr && hit_div;
  wire ld_ctrl = (state_reg == oc6_pkg::OC6_ST_RD_DIV);
  wire ld_div = (state_reg == oc6_pkg::OC6_ST_LD_DIV);

  assign nvm.rd_en = (state_reg == oc6_pkg::OC6_ST_RD_CTRL) || ld_ctrl;
  assign nvm.rd_addr = ld_ctrl ? `OC6_NVM_IDX_DIV : `OC6_NVM_IDX_CTRL;
  assign nvm.wr_en = i_nvm_wr;
  assign nvm.wr_addr = i_nvm_addr;
  assign nvm.wr_data = i_nvm_data;

  // a bus write in the same cycle beats the image load
  assign ctrl_next = wr_ctrl ? i_wr_data : ld_ctrl ? nvm.rd_data : ctrl_reg; // R12
  assign div_next = wr_div ? i_wr_data : ld_div ? nvm.rd_data : div_reg; // R06

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      oc6_pkg::OC6_ST_RD_CTRL: state_next = oc6_pkg::OC6_ST_RD_DIV;
      oc6_pkg::OC6_ST_RD_DIV: state_next = oc6_pkg::OC6_ST_LD_DIV;
      oc6_pkg::OC6_ST_LD_DIV: state_next = oc6_pkg::OC6_ST_RUN;
      oc6_pkg::OC6_ST_RUN: state_next = oc6_pkg::OC6_ST_RUN;
      default: state_next = oc6_pkg::OC6_ST_RD_CTRL;
    endcase
  end

  // unmapped reads answer zero
  assign rd_data_next = !i_rd ? `OC6_RD_IDLE : hit_ctrl ? ctrl_reg : hit_div ? div_reg : `OC6_RD_IDLE;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      ctrl_reg <= `OC6_CTRL_RST; // R01
      div_reg <= `OC6_DIV_RST; // R09
      rd_data_reg <= `OC6_RD_IDLE;
      init_done_reg <= 1'b0;
      state_reg <= oc6_pkg::OC6_ST_RD_CTRL;
    end else begin
      ctrl_reg <= ctrl_next;
      div_reg <= div_next;
      rd_data_reg <= rd_data_next;
      init_done_reg <= (state_next == oc6_pkg::OC6_ST_RUN);
      state_reg <= state_next;
    end
  end

  // --------------------------------------------------------------------
  // field decode
  // --------------------------------------------------------------------
  oc6_pkg::oc6_src_t src_sel;
  oc6_pkg::oc6_fmt_t fmt_sel;
  wire [1:0] mode_first = ctrl_reg[`OC6_M1_MSB:`OC6_M1_LSB];
  wire [1:0] mode_second = ctrl_reg[`OC6_M2_MSB:`OC6_M2_LSB];

  assign src_sel = oc6_pkg::oc6_src_t'(ctrl_reg[`OC6_SRC_MSB:`OC6_SRC_LSB]); // R01
  assign fmt_sel = oc6_pkg::oc6_fmt_t'(ctrl_reg[`OC6_FMT_MSB:`OC6_FMT_LSB]); // R02

  wire is_hcsl = (fmt_sel == oc6_pkg::OC6_FMT_HCSL);
  wire is_cmos = (fmt_sel == oc6_pkg::OC6_FMT_CMOS);
  wire is_diff = (fmt_sel == oc6_pkg::OC6_FMT_ACDIFF) || is_hcsl;
  wire use_div = (src_sel == oc6_pkg::OC6_SRC_SYNTH); // R08

  // --------------------------------------------------------------------
  // source mux and divider
  // --------------------------------------------------------------------
  wire synth_clk = i_second_synth_path_sel ? i_second_synth_clk : i_synth_clk; // R08
  wire pri_clk = i_ref_doubler_en ? i_pri_ref_x2 : i_pri_ref; // R11
  wire sec_clk = i_ref_doubler_en ? i_sec_ref_x2 : i_sec_ref; // R11
  wire src_raw = (src_sel == oc6_pkg::OC6_SRC_SYNTH) ? synth_clk :
                 (src_sel == oc6_pkg::OC6_SRC_PRI) ? pri_clk :
                 (src_sel == oc6_pkg::OC6_SRC_SEC) ? sec_clk : 1'b0; // R13

  logic src_level_reg;
  logic src_prev_reg;
  logic div_clk;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      src_level_reg <= 1'b0;
      src_prev_reg <= 1'b0;
    end else begin
      src_level_reg <= src_raw;
      src_prev_reg <= src_level_reg;
    end
  end

  wire src_edge = src_level_reg ^ src_prev_reg;

  oc6_divider u_div (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_enable(use_div),
    .i_edge(src_edge),
    .i_ratio(div_reg),
    .o_clk(div_clk)
  );

  // references go straight to the driver
  wire core_clk = use_div ? div_clk : src_level_reg; // R10

  // --------------------------------------------------------------------
  // driver format
  // --------------------------------------------------------------------
  wire [1:0] cmos_p = oc6_pin_drive(mode_first, core_clk); // R03
  wire [1:0] cmos_n = oc6_pin_drive(mode_second, core_clk); // R05
  wire hcsl_tri = is_hcsl && (mode_second == 2'b00); // R05

  wire p_oe_next = is_cmos ? cmos_p[1] : (is_diff && !hcsl_tri); // R02
  wire n_oe_next = is_cmos ? cmos_n[1] : (is_diff && !hcsl_tri);
  wire p_next = is_cmos ? cmos_p[0] : (is_diff && core_clk);
  wire n_next = is_cmos ? cmos_n[0] : (is_diff && !core_clk);

  wire [4:0] tail_next = !is_diff ? `OC6_TAIL_OFF :
                         (mode_first == 2'b00) ? `OC6_TAIL_4MA :
                         (mode_first == 2'b01) ? `OC6_TAIL_6MA :
                         (mode_first == 2'b10) ? `OC6_TAIL_8MA :
                         is_hcsl ? `OC6_TAIL_16MA : `OC6_TAIL_8MA; // R04
  wire [7:0] load_next = !is_hcsl ? `OC6_LOAD_NONE :
                         (mode_second == 2'b01) ? `OC6_LOAD_50 :
                         (mode_second == 2'b10) ? `OC6_LOAD_100 :
                         (mode_second == 2'b11) ? `OC6_LOAD_200 : `OC6_LOAD_NONE; // R05

  logic out_p_reg;
  logic out_p_oe_reg;
  logic out_n_reg;
  logic out_n_oe_reg;
  logic [4:0] tail_reg;
  logic [7:0] load_reg;
  logic div_active_reg;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      out_p_reg <= 1'b0;
      out_p_oe_reg <= 1'b0;
      out_n_reg <= 1'b0;
      out_n_oe_reg <= 1'b0;
      tail_reg <= `OC6_TAIL_OFF;
      load_reg <= `OC6_LOAD_NONE;
      div_active_reg <= 1'b0;
    end else begin
      out_p_reg <= p_next;
      out_p_oe_reg <= p_oe_next;
      out_n_reg <= n_next;
      out_n_oe_reg <= n_oe_next;
      tail_reg <= tail_next;
      load_reg <= load_next;
      div_active_reg <= use_div;
    end
  end

  assign o_out_p = out_p_reg;
  assign o_out_p_oe = out_p_oe_reg;
  assign o_out_n = out_n_reg;
  assign o_out_n_oe = out_n_oe_reg;
  assign o_tail_ma = tail_reg;
  assign o_load_ohm = load_reg;
  assign o_div_active = div_active_reg;
  assign o_init_done = init_done_reg;
  assign o_rd_data = rd_data_reg;

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  chk_ctrl_reset: assert property (disable iff (1'b0) !i_rst_n |=> ctrl_reg == `OC6_CTRL_RST) // R01
    else $error("control register reset value wrong");
  chk_div_reset: assert property (disable iff (1'b0) !i_rst_n |=> div_reg == `OC6_DIV_RST) // R09
    else $error("divider register reset value wrong");
  chk_fmt_off: assert property ((fmt_sel == oc6_pkg::OC6_FMT_OFF) |=> (!o_out_p_oe && !o_out_n_oe)) // R02
    else $error("disabled format still drives");
  chk_cmos_pin_p: assert property ((is_cmos && mode_first == 2'b01) |=> (o_out_p_oe && !o_out_p)) // R03
    else $error("cmos positive pin not driven low");
  chk_tail_hcsl: assert property ((is_hcsl && mode_first == 2'b11) |=> o_tail_ma == `OC6_TAIL_16MA) // R04
    else $error("hcsl tail current wrong");
  chk_hcsl_load: assert property ((is_hcsl && mode_second == 2'b10) |=> o_load_ohm == `OC6_LOAD_100) // R05
    else $error("hcsl load wrong");
  chk_ref_bypass: assert property ((!use_div && fmt_sel == oc6_pkg::OC6_FMT_ACDIFF) |=> // R10
    (o_out_p == $past(src_level_reg) && o_out_n != o_out_p))
    else $error("reference not passed straight to driver");
  chk_doubler_path: assert property ((src_sel == oc6_pkg::OC6_SRC_PRI && i_ref_doubler_en) |=> // R11
    src_level_reg == $past(i_pri_ref_x2))
    else $error("doubled reference not selected");
  chk_rsvd_mute: assert property ((src_sel == oc6_pkg::OC6_SRC_RSVD) |=> !src_level_reg) // R13
    else $error("reserved source produced a clock");
  chk_image_load: assert property ((ld_ctrl && !wr_ctrl) |=> ctrl_reg == $past(nvm.rd_data)) // R12
    else $error("image not loaded into control register");
  chk_div_readback: assert property ((i_rd && hit_div) |=> o_rd_data == $past(div_reg)) // R06
    else $error("divider read back wrong");
  chk_init_time: assert property ($rose(i_rst_n) |-> ##[1:3] o_init_done) // R12
    else $error("start-up load too slow");
  // a bus write must win even in the image load cycle
  chk_write_wins: assert property (wr_div |=> div_reg == $past(i_wr_data)) // R12
    else $error("divider write lost");
  chk_rd_idle: assert property (!i_rd |=> o_rd_data == `OC6_RD_IDLE) // R06
    else $error("read data not idle outside a read");

  // --------------------------------------------------------------------
  // source path and driver checks
  // --------------------------------------------------------------------
  chk_synth_select: assert property ((use_div && !i_second_synth_path_sel) |=> // R08
    src_level_reg == $past(i_synth_clk))
    else $error("synthesizer clock not selected");
  chk_second_path: assert property ((use_div && i_second_synth_path_sel) |=> // R08
    src_level_reg == $past(i_second_synth_clk))
    else $error("second synthesizer path not selected");
  chk_div_status: assert property ((src_sel != oc6_pkg::OC6_SRC_SYNTH) |=> !o_div_active) // R08
    else $error("divider flagged active on a reference");
  chk_tail_off: assert property (!is_diff |=> o_tail_ma == `OC6_TAIL_OFF) // R04
    else $error("tail current set outside differential formats");
  chk_cmos_pin_n: assert property ((is_cmos && mode_second == 2'b01) |=> (o_out_n_oe && !o_out_n)) // R05
    else $error("cmos negative pin not driven low");

  cov_hcsl_out: cover property (is_hcsl && o_out_p_oe);
  cov_cmos_out: cover property (is_cmos && o_out_p_oe && o_out_n_oe);
  cov_div_run: cover property (use_div && $rose(div_clk));
  cov_write_during_load: cover property (ld_ctrl && wr_ctrl);
  cov_ref_out: cover property (!use_div && o_out_p_oe && o_out_n_oe);

endmodule : oc6_output_ctrl

// ---- oc6_output_ctrl_tb.sv ----
// self-checking bench for the channel six output control block
// assumes oc6_output_ctrl and oc6_params.svh in the same compile, 20 MHz clock
`timescale 1ns/1ps
`include "oc6_params.svh"

module oc6_output_ctrl_tb;
  // --------------------------------------------------------------------
  // signals
  // --------------------------------------------------------------------
  logic i_mclk;
  logic i_rst_n;
  logic [7:0] i_addr;
  logic [7:0] i_wr_data;
  logic i_wr;
  logic i_rd;
  logic [7:0] o_rd_data;
  logic i_nvm_wr;
  logic i_nvm_addr;
  logic [7:0] i_nvm_data;
  logic i_synth_clk = 1'b0;
  logic i_second_synth_clk = 1'b0;
  logic i_second_synth_path_sel;
  logic i_pri_ref = 1'b0;
  logic i_pri_ref_x2 = 1'b0;
  logic i_sec_ref = 1'b0;
  logic i_sec_ref_x2 = 1'b0;
  logic i_ref_doubler_en;
  logic o_out_p;
  logic o_out_p_oe;
  logic o_out_n;
  logic o_out_n_oe;
  logic [4:0] o_tail_ma;
  logic [7:0] o_load_ohm;
  logic o_div_active;
  logic o_init_done;
  logic obs_req;
  logic [1:0] obs_sel;
  logic [15:0] meas_v;
  logic rd_q = 1'b0;
  logic rd_q2 = 1'b0;
  logic [16:0] obs_val;
  logic [7:0] rq[$];
  logic [16:0] oq[$];
  int fails;
  int n_tests;
  int cyc = 0;
  logic [31:0] rnd;
  localparam int TMO = 20000;
  // clock path table: control, divider, second path, doubler, period in cycles
  logic [7:0] ck_ctrl [0:8] = '{8'h10, 8'h10, 8'h10, 8'h10, 8'h10, 8'h90, 8'h90, 8'hD0, 8'hD0};
  logic [7:0] ck_div [0:8] = '{8'h00, 8'h01, 8'h05, 8'hFF, 8'h02, 8'h03, 8'h03, 8'h03, 8'h03};
  logic ck_s2 [0:8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
  logic ck_dbl [0:8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
  logic [15:0] ck_per [0:8] = '{16'h0004, 16'h0008, 16'h0018, 16'h0400, 16'h0012, 16'h0004, 16'h0002,
                               16'h0008, 16'h0004};

  assign obs_val = (obs_sel == 2'd0) ? {o_init_done, o_div_active, o_out_p_oe, o_out_n_oe, o_tail_ma, o_load_ohm} :
                   (obs_sel == 2'd1) ? {1'b0, meas_v} :
                   {13'h0, o_out_p_oe, o_out_n_oe, o_out_p ^ o_out_n, o_out_p | o_out_n};

  oc6_output_ctrl DUT (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_addr(i_addr),
    .i_wr_data(i_wr_data),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .o_rd_data(o_rd_data),
    .i_nvm_wr(i_nvm_wr),
    .i_nvm_addr(i_nvm_addr),
    .i_nvm_data(i_nvm_data),
    .i_synth_clk(i_synth_clk),
    .i_second_synth_clk(i_second_synth_clk),
    .i_second_synth_path_sel(i_second_synth_path_sel),
    .i_pri_ref(i_pri_ref),
    .i_pri_ref_x2(i_pri_ref_x2),
    .i_sec_ref(i_sec_ref),
    .i_sec_ref_x2(i_sec_ref_x2),
    .i_ref_doubler_en(i_ref_doubler_en),
    .o_out_p(o_out_p),
    .o_out_p_oe(o_out_p_oe),
    .o_out_n(o_out_n),
    .o_out_n_oe(o_out_n_oe),
    .o_tail_ma(o_tail_ma),
    .o_load_ohm(o_load_ohm),
    .o_div_active(o_div_active),
    .o_init_done(o_init_done)
  );

  // --------------------------------------------------------------------
  // clock, source clocks, timeout
  // --------------------------------------------------------------------
  initial begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end

  // source periods: synth 4, second synth 6, ref 4, ref x2 2, sec ref 8, sec x2 4
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc % 2 == 0) begin
      i_synth_clk <= ~i_synth_clk;
      i_pri_ref <= ~i_pri_ref;
      i_sec_ref_x2 <= ~i_sec_ref_x2;
    end
    if (cyc % 3 == 0) begin
      i_second_synth_clk <= ~i_second_synth_clk;
    end
    if (cyc % 4 == 0) begin
      i_sec_ref <= ~i_sec_ref;
    end
    i_pri_ref_x2 <= ~i_pri_ref_x2;
    if (cyc == TMO) begin
      fails++;
      finish_test();
    end
  end

  // --------------------------------------------------------------------
  // monitor: oldest note against the result
  // --------------------------------------------------------------------
  task automatic cmp(input logic [16:0] e, input logic [16:0] a);
    n_tests++;
    if (e !== a) begin
      fails++;
      $display("Error at %0t: expected %h got %h", $time, e, a);
    end
  endtask : cmp

  always @(posedge i_mclk) begin
    rd_q <= i_rd;
    rd_q2 <= rd_q;
    if (rd_q) begin
      cmp({9'h0, rq.pop_front()}, {9'h0, o_rd_data});
    end else if (rd_q2) begin
      cmp(17'h0, {9'h0, o_rd_data});
    end
    if (obs_req) begin
      cmp(oq.pop_front(), obs_val);
    end
  end

  // --------------------------------------------------------------------
  // drivers and expectations
  // --------------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  function automatic logic [16:0] exp_mode(input logic [7:0] v, input logic done);
    logic [4:0] t;
    logic [7:0] l;
    logic [1:0] oe;
    t = `OC6_TAIL_OFF;
    l = `OC6_LOAD_NONE;
    oe = 2'b11;
    if (v[5:4] == 2'd1 || v[5:4] == 2'd2) begin
      case (v[3:2])
        2'd0: t = `OC6_TAIL_4MA;
        2'd1: t = `OC6_TAIL_6MA;
        2'd2: t = `OC6_TAIL_8MA;
        default: t = (v[5:4] == 2'd2) ? `OC6_TAIL_16MA : `OC6_TAIL_8MA;
      endcase
    end
    if (v[5:4] == 2'd2) begin
      case (v[1:0])
        2'd0: l = `OC6_LOAD_NONE;
        2'd1: l = `OC6_LOAD_50;
        2'd2: l = `OC6_LOAD_100;
        default: l = `OC6_LOAD_200;
      endcase
    end
    if (v[5:4] == 2'd0 || (v[5:4] == 2'd2 && v[1:0] == 2'd0)) begin
      oe = 2'b00;
    end
    if (v[5:4] == 2'd3) begin
      oe = {v[3:2] != 2'd0, v[1:0] != 2'd0};
    end
    return {done, v[7:6] == 2'd0, oe, t, l};
  endfunction : exp_mode

  task automatic step(input logic w, input logic r, input logic o, input logic [7:0] a, input logic [7:0] d);
    i_wr <= w;
    i_rd <= r;
    obs_req <= o;
    i_addr <= a;
    i_wr_data <= d;
    @(posedge i_mclk);
  endtask : step

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    step(1'b1, 1'b0, 1'b0, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rq.push_back(e);
    step(1'b0, 1'b1, 1'b0, a, 8'h00);
  endtask : rd

  task automatic idle(input int n);
    repeat (n) step(1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
  endtask : idle

  task automatic obs(input logic [1:0] sel, input logic [16:0] e);
    oq.push_back(e);
    obs_sel <= sel;
    step(1'b0, 1'b0, 1'b1, 8'h00, 8'h00);
  endtask : obs

  task automatic do_reset(input logic [7:0] ctrl_exp);
    int n;
    i_rst_n <= 1'b0;
    idle(1);
    obs(2'd0, 17'h0);
    i_rst_n <= 1'b1;
    n = 0;
    while (o_init_done !== 1'b1 && n < 8) begin
      idle(1);
      n++;
    end
    obs(2'd0, exp_mode(ctrl_exp, 1'b1));
  endtask : do_reset

  // cycles from one rising edge of the positive pin to the next
  task automatic rise(output int n);
    logic last;
    n = 0;
    last = o_out_p;
    forever begin
      @(posedge i_mclk);
      n++;
      if ((o_out_p === 1'b1 && last === 1'b0) || n > 3000) break;
      last = o_out_p;
    end
  endtask : rise

  task finish_test;
    $display("Checks: %0d, mismatches: %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test

  // --------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------
  initial begin
    logic [7:0] nv_c;
    logic [7:0] nv_d;
    int n;
    {i_rst_n, i_addr, i_wr_data, i_wr, i_rd, i_nvm_wr, i_nvm_addr, i_nvm_data} = '0;
    {i_second_synth_path_sel, i_ref_doubler_en, obs_req, obs_sel, meas_v} = '0;
    fails = 0;
    n_tests = 0;
    rnd = 32'h0000_0054;
    @(posedge i_mclk);
    do_reset(`OC6_CTRL_RST);
    rd(`OC6_ADDR_CTRL, `OC6_CTRL_RST);
    rd(`OC6_ADDR_DIV, `OC6_DIV_RST);
    for (int v = 0; v < 256; v++) begin
      wr(`OC6_ADDR_CTRL, v[7:0]);
      idle(2);
      obs(2'd0, exp_mode(v[7:0], 1'b1));
      rd(`OC6_ADDR_CTRL, v[7:0]);
    end
    for (int i = 0; i < 6; i++) begin
      rnd = xs(rnd);
      wr(`OC6_ADDR_DIV, rnd[7:0]);
      rd(`OC6_ADDR_DIV, rnd[7:0]);
    end
    wr(8'h28, 8'hA5);
    wr(8'h2B, 8'h5A);
    rd(`OC6_ADDR_CTRL, 8'hFF);
    rd(`OC6_ADDR_DIV, rnd[7:0]);
    rd(8'h2B, 8'h00);
    for (int i = 0; i < 9; i++) begin
      i_second_synth_path_sel <= ck_s2[i];
      i_ref_doubler_en <= ck_dbl[i];
      wr(`OC6_ADDR_CTRL, ck_ctrl[i]);
      wr(`OC6_ADDR_DIV, ck_div[i]);
      idle(1);
      rise(n);
      rise(n);
      rise(n);
      meas_v <= n[15:0];
      obs(2'd1, {1'b0, ck_per[i]});
      obs(2'd2, 17'h0000F);
    end
    wr(`OC6_ADDR_CTRL, 8'hB5);
    idle(3);
    obs(2'd2, 17'h0000C);
    wr(`OC6_ADDR_CTRL, 8'hBE);
    idle(3);
    obs(2'd2, 17'h0000F);
    idle(1);
    rnd = xs(rnd);
    nv_c = {2'b10, rnd[5:0]};
    rnd = xs(rnd);
    nv_d = rnd[7:0];
    i_nvm_wr <= 1'b1;
    i_nvm_addr <= 1'b0;
    i_nvm_data <= nv_c;
    @(posedge i_mclk);
    i_nvm_addr <= 1'b1;
    i_nvm_data <= nv_d;
    @(posedge i_mclk);
    i_nvm_wr <= 1'b0;
    do_reset(nv_c);
    rd(`OC6_ADDR_CTRL, nv_c);
    rd(`OC6_ADDR_DIV, nv_d);
    wr(`OC6_ADDR_CTRL, 8'h18);
    wr(`OC6_ADDR_DIV, 8'h07);
    rd(`OC6_ADDR_CTRL, 8'h18);
    rd(`OC6_ADDR_DIV, 8'h07);
    idle(3);
    finish_test();
  end
endmodule : oc6_output_ctrl_tb

// ---- oc6_params.svh ----
// constants for the channel six output control block: offsets, fields, resets
// assumes inclusion by bare name from each design file
`ifndef OC6_PARAMS_SVH
`define OC6_PARAMS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define OC6_ADDR_CTRL 8'h29
`define OC6_ADDR_DIV 8'h2A

// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define OC6_SRC_MSB 7
`define OC6_SRC_LSB 6
`define OC6_FMT_MSB 5
`define OC6_FMT_LSB 4
`define OC6_M1_MSB 3
`define OC6_M1_LSB 2
`define OC6_M2_MSB 1
`define OC6_M2_LSB 0

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define OC6_CTRL_RST 8'h18
`define OC6_DIV_RST 8'h05
`define OC6_RD_IDLE 8'h00

// ----------------------------------------------------------------------
// driver strengths and loads
// ----------------------------------------------------------------------
`define OC6_TAIL_OFF 5'h00
`define OC6_TAIL_4MA 5'h04
`define OC6_TAIL_6MA 5'h06
`define OC6_TAIL_8MA 5'h08
`define OC6_TAIL_16MA 5'h10
`define OC6_LOAD_NONE 8'h00
`define OC6_LOAD_50 8'h32
`define OC6_LOAD_100 8'h64
`define OC6_LOAD_200 8'hC8

// ----------------------------------------------------------------------
// non-volatile image
// ----------------------------------------------------------------------
`define OC6_NVM_IDX_CTRL 1'h0
`define OC6_NVM_IDX_DIV 1'h1

`endif

// ---- oc6_pkg.sv ----
// types of the channel six output control block
// assumes nothing beyond a SystemVerilog compiler
package oc6_pkg;

  // --------------------------------------------------------------------
  // field encodings
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    OC6_SRC_SYNTH = 2'b00,
    OC6_SRC_RSVD = 2'b01,
    OC6_SRC_PRI = 2'b10,
    OC6_SRC_SEC = 2'b11
  } oc6_src_t;

  typedef enum logic [1:0] {
    OC6_FMT_OFF = 2'b00,
    OC6_FMT_ACDIFF = 2'b01,
    OC6_FMT_HCSL = 2'b10,
    OC6_FMT_CMOS = 2'b11
  } oc6_fmt_t;

  typedef enum logic [1:0] {
    OC6_PIN_TRI = 2'b00,
    OC6_PIN_LOW = 2'b01,
    OC6_PIN_INV = 2'b10,
    OC6_PIN_TRUE = 2'b11
  } oc6_pin_t;

  // --------------------------------------------------------------------
  // start-up load sequence
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    OC6_ST_RD_CTRL = 2'b00,
    OC6_ST_RD_DIV = 2'b01,
    OC6_ST_LD_DIV = 2'b10,
    OC6_ST_RUN = 2'b11
  } oc6_state_t;

endpackage : oc6_pkg
